// ---- inc/gcr_consts.svh ----
// Offsets, key values, field positions and reset values of the global option registers.
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Configuration port addresses and keys
// ----------------------------------------------------------------------------
`define GCR_PORT_BASE_LOW   16'h002E
`define GCR_PORT_BASE_HIGH  16'h004E
`define GCR_ENTRY_KEY       8'h87
`define GCR_EXIT_KEY        8'hAA

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define GCR_IDX_MULTI_FUNC  8'h24
`define GCR_IDX_TRISTATE    8'h25
`define GCR_IDX_STRAPPED    8'h26

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define GCR_MULTI_FUNC_RST  8'h00
`define GCR_TRISTATE_RST    8'h00
`define GCR_STRAPPED_RST    8'h00
`define GCR_STRAPPED_MASK   8'h6F
`define GCR_UNMAPPED_DATA   8'h00
`define GCR_STRAP_SYNC_LEN  2'h2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GCR_SG_PORT_SEL     6
`define GCR_SG_LOCK         5
`define GCR_SG_FDC_LEG      3
`define GCR_SG_PRT_LEG      2
`define GCR_SG_UART1_LEG    1
`define GCR_SG_UART2_LEG    0
`define GCR_MF_FLOPPY_PINS  7
`define GCR_MF_SYS_FAN_OD   6
`define GCR_MF_CPU_FAN_OD   5
`define GCR_MF_AUX_FAN_OD   4
`define GCR_MF_OE3          3
`define GCR_MF_IR_OE        2
`define GCR_MF_BEEPER_OUTPUT_OE      1
`define GCR_MF_PNP_DEFAULT  0

`endif

// ---- inc/gcr_pkg.sv ----
// Types of the global option register block.
package gcr_pkg;

	typedef enum logic [2:0] {
		GCR_IDLE   = 3'b001,
		GCR_KEYED1 = 3'b010,
		GCR_CONFIG = 3'b100
	} gcr_mode_t;

	typedef struct packed {
		logic [1:0]  strap_sync;
		logic [1:0]  strap_cnt;
		logic        strap_done;
		gcr_mode_t   mode;
		logic [7:0]  index;
		logic [7:0]  multi_func;
		logic [7:0]  tristate;
		logic [7:0]  strapped;
		logic [7:0]  rdata;
		logic        rvalid;
	} gcr_state_t;

endpackage

// ---- hw/gcr_top.sv ----
// Global configuration option registers behind the index/data configuration port.
`timescale 1ns/1ps
`include "gcr_consts.svh"

// ----------------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------------
// Overview of operation
// - Port select bit picks 2E or 4E key port.
// - Port select resets to 0, then takes strapped RTS pin level three cycles later.
// - Lock bit blocks access to the tri-state and multi-function registers.
// - Floppy legacy bit gates floppy IRQ select bit.
// - Parallel legacy bit gates parallel IRQ select bit.
// - Strapped register resets zero, bit6 strap, 7,4 reserved.
// - One tri-state bit per interface, set floats pins.
// - Tri-state register 8 bits, RW, resets 00h.
// - Bit 0 selects plug-and-play default loading.

module gcr_top (
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        io_wr_in,
	input  wire logic        io_rd_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic [7:0]  io_wdata_in,
	output logic      [7:0]  io_rdata_out,
	output logic             io_rvalid_out,
	output logic             io_hit_out,
	input  wire logic        first_uart_rts_strap_pin_in,
	input  wire logic        floppy_dor_irq_bit_in,
	input  wire logic        parallel_ctrl_irq_bit_in,
	input  wire logic        infrared_transmit_in,
	input  wire logic        consumer_ir_transmit_in,
	input  wire logic        consumer_ir_select_in,
	input  wire logic        beeper_output_in,
	output logic             config_mode_out,
	output logic             config_port_base_select_out,
	output logic             config_write_lock_out,
	output logic             floppy_legacy_irq_disable_out,
	output logic             parallel_legacy_irq_disable_out,
	output logic             uart_first_legacy_irq_disable_out,
	output logic             uart_second_legacy_irq_disable_out,
	output logic             floppy_irq_select_effective_out,
	output logic             parallel_irq_select_effective_out,
	output logic      [7:0]  interface_tristate_out,
	output logic             pnp_default_value_select_out,
	output logic             floppy_pin_mode_out,
	output logic      [2:0]  fan_open_drain_out,
	output logic             output_enable_3_out,
	output logic             ir_pin_out,
	output logic             ir_pin_oe_n_out,
	output logic             beeper_output_pin_out,
	output logic             beeper_output_pin_oe_n_out
);

	gcr_pkg::gcr_state_t st_r;
	gcr_pkg::gcr_state_t st_nxt;

	// ------------------------------------------------------------------------
	// Port decode
	// ------------------------------------------------------------------------
	// Key port follows the current port select bit.
	function automatic logic [15:0] gcr_base(input logic sel);
		gcr_base = sel ? `GCR_PORT_BASE_HIGH : `GCR_PORT_BASE_LOW;
	endfunction

	logic [15:0] base_addr;
	logic        idx_hit;
	logic        dat_hit;
	logic        locked;

	assign base_addr = gcr_base(st_r.strapped[`GCR_SG_PORT_SEL]);
	assign idx_hit   = (io_addr_in == base_addr);
	assign dat_hit   = (io_addr_in == (base_addr + 16'h0001));
	assign locked    = st_r.strapped[`GCR_SG_LOCK];

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		st_nxt        = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.strap_sync = {st_r.strap_sync[0], first_uart_rts_strap_pin_in};

		// The strap is taken once, after the synchroniser has filled, so the
		// reset constant of the sync flops never reaches the register.
		if (!st_r.strap_done) begin
			if (st_r.strap_cnt == `GCR_STRAP_SYNC_LEN) begin
				st_nxt.strap_done = 1'b1;
				st_nxt.strapped[`GCR_SG_PORT_SEL] = st_r.strap_sync[1];
			end else begin
				st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
			end
		end

		case (st_r.mode)
			gcr_pkg::GCR_IDLE: begin
				if (io_wr_in && idx_hit && io_wdata_in == `GCR_ENTRY_KEY) begin
					st_nxt.mode = gcr_pkg::GCR_KEYED1;
				end
			end
			gcr_pkg::GCR_KEYED1: begin
				if (io_wr_in) begin
					if (idx_hit && io_wdata_in == `GCR_ENTRY_KEY) begin
						st_nxt.mode = gcr_pkg::GCR_CONFIG;
					end else begin
						// A stray write between the two keys aborts the entry, so a
						// half-finished sequence never leaves the port open.
						st_nxt.mode = gcr_pkg::GCR_IDLE;
					end
				end
			end
			gcr_pkg::GCR_CONFIG: begin
				if (io_wr_in && idx_hit) begin
					if (io_wdata_in == `GCR_EXIT_KEY) begin
						st_nxt.mode = gcr_pkg::GCR_IDLE;
					end else begin
						// A key value seen here is only an index; just the exit key leaves.
						st_nxt.index = io_wdata_in;
					end
				end else if (io_wr_in && dat_hit) begin
					// The strapped register stays writable so a lock can be lifted.
					// The lock therefore covers the other registers of this block only.
					if (st_r.index == `GCR_IDX_STRAPPED) begin
						st_nxt.strapped = io_wdata_in & `GCR_STRAPPED_MASK;
					end else if (locked) begin
						st_nxt.index = st_r.index;
					end else if (st_r.index == `GCR_IDX_TRISTATE) begin
						st_nxt.tristate = io_wdata_in;
					end else if (st_r.index == `GCR_IDX_MULTI_FUNC) begin
						st_nxt.multi_func = io_wdata_in;
					end
				end
				// A read is answered one cycle later. Outside configuration mode no
				// answer is given, so another device may claim the same port.
				if (io_rd_in && idx_hit) begin
					st_nxt.rvalid = 1'b1;
					st_nxt.rdata  = st_r.index;
				end else if (io_rd_in && dat_hit) begin
					st_nxt.rvalid = 1'b1;
					if (st_r.index == `GCR_IDX_STRAPPED) begin
						st_nxt.rdata = st_r.strapped;
					end else if (locked) begin
						st_nxt.rdata = `GCR_UNMAPPED_DATA;
					end else if (st_r.index == `GCR_IDX_TRISTATE) begin
						st_nxt.rdata = st_r.tristate;
					end else if (st_r.index == `GCR_IDX_MULTI_FUNC) begin
						st_nxt.rdata = st_r.multi_func;
					end else begin
						st_nxt.rdata = `GCR_UNMAPPED_DATA;
					end
				end
			end
			// An illegal state code falls back to idle and waits for a fresh key.
			default: begin
				st_nxt.mode = gcr_pkg::GCR_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	// Every reset value is a constant; the strap reaches bit 6 only through the
	// synchroniser, a few cycles after reset is released.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r.strap_sync <= 2'h0;
			st_r.strap_cnt  <= 2'h0;
			st_r.strap_done <= 1'b0;
			st_r.mode       <= gcr_pkg::GCR_IDLE;
			st_r.index      <= 8'h00;
			st_r.multi_func <= `GCR_MULTI_FUNC_RST;
			st_r.tristate   <= `GCR_TRISTATE_RST;
			st_r.strapped   <= `GCR_STRAPPED_RST;
			st_r.rdata      <= 8'h00;
			st_r.rvalid     <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	// The hit output decodes combinationally; read data, read valid and register contents come from flops.
	assign io_rdata_out  = st_r.rdata;
	assign io_rvalid_out = st_r.rvalid;
	assign io_hit_out    = (st_r.mode == gcr_pkg::GCR_CONFIG) && (idx_hit || dat_hit);

	assign config_mode_out                    = (st_r.mode == gcr_pkg::GCR_CONFIG);
	assign config_port_base_select_out        = st_r.strapped[`GCR_SG_PORT_SEL];
	assign config_write_lock_out              = locked;
	assign floppy_legacy_irq_disable_out      = st_r.strapped[`GCR_SG_FDC_LEG];
	assign parallel_legacy_irq_disable_out    = st_r.strapped[`GCR_SG_PRT_LEG];
	assign uart_first_legacy_irq_disable_out  = st_r.strapped[`GCR_SG_UART1_LEG];
	assign uart_second_legacy_irq_disable_out = st_r.strapped[`GCR_SG_UART2_LEG];

	// With a legacy bit set the interface's own select bit is ignored, so the
	// effective select is held low whatever that bit holds.
	assign floppy_irq_select_effective_out =
		floppy_dor_irq_bit_in & ~st_r.strapped[`GCR_SG_FDC_LEG];
	assign parallel_irq_select_effective_out =
		parallel_ctrl_irq_bit_in & ~st_r.strapped[`GCR_SG_PRT_LEG];

	assign interface_tristate_out       = st_r.tristate;
	assign pnp_default_value_select_out = st_r.multi_func[`GCR_MF_PNP_DEFAULT];
	assign floppy_pin_mode_out          = st_r.multi_func[`GCR_MF_FLOPPY_PINS];
	assign fan_open_drain_out           =
		st_r.multi_func[`GCR_MF_SYS_FAN_OD:`GCR_MF_AUX_FAN_OD];
	assign output_enable_3_out          = st_r.multi_func[`GCR_MF_OE3];

	// In floppy pin mode pins 16 and 18 become floppy inputs, so both are released.
	assign ir_pin_out      = consumer_ir_select_in ? consumer_ir_transmit_in
	                                               : infrared_transmit_in;
	assign ir_pin_oe_n_out = st_r.multi_func[`GCR_MF_FLOPPY_PINS] |
	                         ~st_r.multi_func[`GCR_MF_IR_OE];
	assign beeper_output_pin_out    = beeper_output_in;
	assign beeper_output_pin_oe_n_out = st_r.multi_func[`GCR_MF_FLOPPY_PINS] |
	                           ~st_r.multi_func[`GCR_MF_BEEPER_OUTPUT_OE];

endmodule // gcr_top

// ---- dv/gcr_props.sv ----
// Port checker of the global option register block.
`timescale 1ns/1ps
module gcr_props (
	input wire logic        core_clk_in,
	input wire logic        reset_n_in,
	input wire logic        io_wr_in,
	input wire logic        io_rd_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [7:0]  io_wdata_in,
	input wire logic        io_rvalid_out,
	input wire logic        io_hit_out,
	input wire logic        config_mode_out,
	input wire logic        config_port_base_select_out,
	input wire logic        config_write_lock_out,
	input wire logic        floppy_dor_irq_bit_in,
	input wire logic        floppy_legacy_irq_disable_out,
	input wire logic        floppy_irq_select_effective_out,
	input wire logic        parallel_ctrl_irq_bit_in,
	input wire logic        parallel_legacy_irq_disable_out,
	input wire logic        parallel_irq_select_effective_out,
	input wire logic [7:0]  interface_tristate_out,
	input wire logic        floppy_pin_mode_out,
	input wire logic        ir_pin_oe_n_out,
	input wire logic        beeper_output_pin_oe_n_out
);
	logic        wr_ok_r;
	logic [15:0] base;
	assign base = config_port_base_select_out ? 16'h004E : 16'h002E;
	// Only an unlocked write that hit the port may move the tri-state register.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ok_r <= 1'b0;
		end else begin
			wr_ok_r <= io_wr_in && io_hit_out && !config_write_lock_out;
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence key_s;
		io_wr_in && !config_mode_out && io_addr_in == base && io_wdata_in == 8'h87;
	endsequence
	chk_key_entry: assert property (
		key_s ##1 !io_wr_in ##1 key_s |=> config_mode_out) else $error("no config mode");
	chk_hit_decode: assert property (
		io_hit_out == (config_mode_out && (io_addr_in == base || io_addr_in == base + 16'h0001)))
		else $error("bad port decode");
	chk_read_answer: assert property (
		io_rd_in && io_hit_out |=> io_rvalid_out) else $error("read not answered");
	chk_lock_hold: assert property (
		!wr_ok_r |-> $stable(interface_tristate_out)) else $error("tri-state moved");
	chk_floppy_gate: assert property (
		floppy_irq_select_effective_out ==
		(floppy_dor_irq_bit_in && !floppy_legacy_irq_disable_out))
		else $error("floppy irq gate");
	chk_parallel_gate: assert property (
		parallel_irq_select_effective_out ==
		(parallel_ctrl_irq_bit_in && !parallel_legacy_irq_disable_out))
		else $error("parallel gate");
	chk_reset_values: assert property (
		$rose(reset_n_in) |-> interface_tristate_out == 8'h00 && !config_write_lock_out)
		else $error("bad reset value");
	chk_floppy_pins: assert property (
		floppy_pin_mode_out |-> ir_pin_oe_n_out && beeper_output_pin_oe_n_out) else $error("pin driven");
endmodule // gcr_props

bind gcr_top gcr_props chk_u (.*);

// ---- dv/gcr_host_model.sv ----
// Host model issuing configuration port strobes.
`timescale 1ns/1ps
module gcr_host_model (
	input  wire logic        clk_in,
	input  wire logic        rvalid_in,
	input  wire logic [7:0]  rdata_in,
	output logic             wr_out,
	output logic             rd_out,
	output logic      [15:0] addr_out,
	output logic      [7:0]  wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 16'h0000;
		wdata_out = 8'h00;
	end
	// Released lines show the inverse so a stale value never passes.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule // gcr_host_model

// ---- dv/tb.sv ----
// Testbench of the global option register block.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module tb;
	logic core_clk_in = 1'b0;
	logic reset_n_in, io_wr_in, io_rd_in, io_rvalid_out, io_hit_out;
	logic [15:0] io_addr_in, port_base;
	logic [7:0] io_wdata_in, io_rdata_out, interface_tristate_out, rd_d;
	logic [3:0] misc = 4'h0;
	logic [2:0] fan_open_drain_out;
	logic first_uart_rts_strap_pin_in, floppy_dor_irq_bit_in, parallel_ctrl_irq_bit_in, rd_v;
	logic config_mode_out, config_port_base_select_out, config_write_lock_out;
	logic floppy_legacy_irq_disable_out, parallel_legacy_irq_disable_out;
	logic uart_first_legacy_irq_disable_out, uart_second_legacy_irq_disable_out;
	logic floppy_irq_select_effective_out, parallel_irq_select_effective_out;
	logic pnp_default_value_select_out, floppy_pin_mode_out, output_enable_3_out;
	logic ir_pin_out, ir_pin_oe_n_out, beeper_output_pin_out, beeper_output_pin_oe_n_out;
	int   mismatches = 0, n_tests = 0, cyc = 0;
	gcr_top dut_u (.*, .infrared_transmit_in(misc[0]), .consumer_ir_transmit_in(misc[1]),
		.consumer_ir_select_in(misc[2]), .beeper_output_in(misc[3]));
	gcr_host_model host_u (.clk_in(core_clk_in), .rvalid_in(io_rvalid_out),
		.rdata_in(io_rdata_out), .wr_out(io_wr_in), .rd_out(io_rd_in),
		.addr_out(io_addr_in), .wdata_out(io_wdata_in));
	always #2.5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		misc <= misc + 4'h1;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic enter();
		host_u.wr(port_base, 8'h87);
		host_u.wr(port_base, 8'h87);
		@(negedge core_clk_in);
	endtask
	task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
		host_u.wr(port_base, i);
		host_u.wr(port_base + 16'h0001, d);
		@(negedge core_clk_in);
	endtask
	task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
		host_u.wr(port_base, i);
		host_u.rd(port_base + 16'h0001, rd_d, rd_v);
		`CHK({rd_v, rd_d}, {1'b1, e})
	endtask
	// Eight cycles of the free-running pin stimulus cover every select and level.
	task automatic pin_check();
		repeat (8) begin
			@(negedge core_clk_in);
			`CHK(ir_pin_out, misc[2] ? misc[1] : misc[0])
			`CHK(beeper_output_pin_out, misc[3])
		end
	endtask
	initial begin
		{reset_n_in, floppy_dor_irq_bit_in, parallel_ctrl_irq_bit_in} = 3'h0;
		first_uart_rts_strap_pin_in = 1'b1;
		repeat (16) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		@(negedge core_clk_in);
		`CHK(config_port_base_select_out, 1'b1)
		port_base = 16'h004E;
		enter();
		`CHK(config_mode_out, 1'b1)
		pin_check();
		cfg_rd(8'h26, 8'h40);
		cfg_wr(8'h26, 8'hFF);
		cfg_rd(8'h26, 8'h6F);
		`CHK(config_write_lock_out, 1'b1)
		`CHK(uart_first_legacy_irq_disable_out, 1'b1)
		`CHK(uart_second_legacy_irq_disable_out, 1'b1)
		@(posedge core_clk_in);
		floppy_dor_irq_bit_in <= 1'b1;
		parallel_ctrl_irq_bit_in <= 1'b1;
		@(negedge core_clk_in);
		`CHK(floppy_irq_select_effective_out, 1'b0)
		`CHK(parallel_irq_select_effective_out, 1'b0)
		cfg_wr(8'h25, 8'h5A);
		cfg_rd(8'h25, 8'h00);
		`CHK(interface_tristate_out, 8'h00)
		cfg_wr(8'h26, 8'h40);
		`CHK(floppy_irq_select_effective_out, 1'b1)
		`CHK(parallel_irq_select_effective_out, 1'b1)
		cfg_wr(8'h25, 8'hA5);
		cfg_rd(8'h25, 8'hA5);
		`CHK(interface_tristate_out, 8'hA5)
		cfg_wr(8'h24, 8'h7F);
		`CHK({floppy_pin_mode_out, fan_open_drain_out, output_enable_3_out}, 5'h0F)
		`CHK({ir_pin_oe_n_out, beeper_output_pin_oe_n_out, pnp_default_value_select_out}, 3'h1)
		cfg_wr(8'h24, 8'h80);
		`CHK({floppy_pin_mode_out, ir_pin_oe_n_out, beeper_output_pin_oe_n_out}, 3'h7)
		`CHK(pnp_default_value_select_out, 1'b0)
		cfg_wr(8'h26, 8'h00);
		`CHK(config_port_base_select_out, 1'b0)
		port_base = 16'h002E;
		host_u.wr(port_base, 8'hAA);
		host_u.rd(16'h002F, rd_d, rd_v);
		`CHK({config_mode_out, rd_v}, 2'b00)
		enter();
		`CHK(config_mode_out, 1'b1)
		@(posedge core_clk_in);
		reset_n_in <= 1'b0;
		first_uart_rts_strap_pin_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		@(negedge core_clk_in);
		`CHK({config_mode_out, config_port_base_select_out}, 2'b00)
		`CHK(interface_tristate_out, 8'h00)
		stop_test();
	end
endmodule // tb
